// File: src/line_interface_status_loopback.sv
`timescale 1ns/1ns
module line_interface_status_loopback
  import line_interface_pkg::*;
(
  input wire logic i_mclk,                // Master clock, 20 MHz
  input wire logic i_reset,               // Sync reset, high
  input wire logic [7:0] i_addr,          // Control port address
  input wire logic [7:0] i_wdata,         // Control port write data
  input wire logic i_wr,                  // Write strobe, one cycle
  input wire logic i_rd,                  // Read strobe, one cycle
  output logic [7:0] o_rdata,             // Read data, one cycle after strobe
  input wire logic i_e1_mode,             // 1 = E1, 0 = T1
  input wire mclk_sel_t i_mclk_sel,       // Prescale and source selects
  output mclk_freq_t o_mclk_freq,         // Decoded master clock rate
  output logic o_cdr_pll_enable,          // Conversion PLL enable
  input wire logic [3:0] i_rx_level_code, // Analog level code, async
  input wire logic i_tx_open_circuit,     // Open circuit detect, async
  input wire logic i_tx_current_limit,    // Limiter active, async
  input wire logic [7:0] i_ja_fill,       // Jitter FIFO fill, bits
  input wire logic i_ja_enable,           // Jitter attenuator in path
  input wire line_pair_t i_rx_line,       // Recovered receive data
  input wire line_pair_t i_tx_fmt,        // Transmit formatter data
  input wire line_pair_t i_ja_out,        // Jitter attenuator output
  output line_pair_t o_ja_in,             // Jitter attenuator input
  output line_pair_t o_rx_framer,         // Data to receive framer
  output line_pair_t o_tx_line,           // Data to transmit driver
  input wire logic i_composite_clock_mode, // Composite clock mode
  input wire logic i_cc_with_400hz,       // Composite variant with 400 Hz
  output logic o_cc_frame_mark,           // 8 kHz violation marker
  output logic o_irq                      // Interrupt request, high
);

  logic [3:0] level_meta;
  logic [3:0] level_sync;
  logic [1:0] fault_meta;
  logic [1:0] fault_sync;
  logic [1:0] fault_prev;
  logic [7:0] irq_mask;
  logic [7:0] loop_ctrl;
  logic pend_open;
  logic pend_limit;
  logic ja_limit_flag;
  logic ja_near_prev;
  line_pair_t cc_line;

  // Configuration decode, kept combinational so it tracks the selects
  function automatic mclk_freq_t decode_mclk(input logic e1, input mclk_sel_t sel);
    mclk_freq_t f;
    f = MCLK_INVALID;
    if (!e1)
    begin
      case (sel.jitter_src)
        2'b00: f = mclk_freq_t'(4'(sel.prescale));
        2'b01:
          case (sel.prescale)
            2'b00: f = MCLK_2048;
            2'b01: f = MCLK_4096;
            2'b10: f = MCLK_8192;
            default: f = MCLK_16384;
          endcase
        2'b11: f = (sel.prescale == 2'b00) ? MCLK_12800 : MCLK_INVALID;
        default: f = MCLK_INVALID;
      endcase
    end
    else
    begin
      case (sel.jitter_src)
        2'b00:
          case (sel.prescale)
            2'b00: f = MCLK_2048;
            2'b01: f = MCLK_4096;
            2'b10: f = MCLK_8192;
            default: f = MCLK_16384;
          endcase
        2'b10: f = (sel.prescale == 2'b00) ? MCLK_12800 : MCLK_INVALID;
        default: f = MCLK_INVALID;
      endcase
    end
    return f;
  endfunction : decode_mclk

  assign o_mclk_freq = decode_mclk(i_e1_mode, i_mclk_sel);
  // Needed even with the attenuator off: recovery shares this clock
  assign o_cdr_pll_enable = |i_mclk_sel.jitter_src;

  // Register decode
  wire sel_level = (i_addr == ADDR_RX_LEVEL);
  wire sel_status = (i_addr == ADDR_FAULT_STATUS);
  wire sel_mask = (i_addr == ADDR_IRQ_MASK);
  wire sel_loop = (i_addr == ADDR_LOOPBACK);
  wire status_rd = i_rd && sel_status;
  wire mask_wr = i_wr && sel_mask;
  wire loop_wr = i_wr && sel_loop;

  wire open_now = fault_sync[0];
  wire limit_now = fault_sync[1];
  wire [7:0] status_word = {3'h0, ja_limit_flag, 1'b0, limit_now, open_now, 1'b0};
  wire [7:0] read_word = sel_level ? {4'h0, level_sync} :
                         sel_status ? status_word :
                         sel_mask ? irq_mask :
                         sel_loop ? loop_ctrl : UNMAPPED_READ;

  // Fault events on either edge of the synchronised condition
  wire open_edge = fault_sync[0] != fault_prev[0];
  wire limit_edge = fault_sync[1] != fault_prev[1];
  // Both ends of the FIFO count as its usable limit
  wire ja_near = (i_ja_fill >= 8'(JA_FIFO_DEPTH - JA_LIMIT_MARGIN)) || (i_ja_fill <= JA_LIMIT_MARGIN);
  wire ja_trip = ja_near && !ja_near_prev;

  // A new event in the read cycle survives the clear
  wire next_pend_open = open_edge || (pend_open && !status_rd);
  wire next_pend_limit = limit_edge || (pend_limit && !status_rd);
  wire next_ja_limit = ja_trip || (ja_limit_flag && !status_rd);
  wire next_irq = (next_pend_open && irq_mask[BIT_OPEN_CIRCUIT]) ||
                  (next_pend_limit && irq_mask[BIT_CURRENT_LIMIT]) ||
                  (next_ja_limit && irq_mask[BIT_JITTER_LIMIT]);

  // Data paths
  wire remote_loop = loop_ctrl[BIT_REMOTE_LOOP];
  wire local_loop = loop_ctrl[BIT_LOCAL_LOOP];
  wire line_pair_t tx_source = i_composite_clock_mode ? cc_line : i_tx_fmt;
  wire line_pair_t next_tx_line = remote_loop ? i_rx_line : tx_source;
  wire line_pair_t next_ja_in = local_loop ? tx_source : i_rx_line;
  wire line_pair_t next_rx_framer = i_ja_enable ? i_ja_out : next_ja_in;

  // Analog-side inputs are asynchronous: two stages before use
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      level_meta <= 4'h0;
      level_sync <= 4'h0;
      fault_meta <= 2'h0;
      fault_sync <= 2'h0;
      fault_prev <= 2'h0;
    end
    else
    begin
      level_meta <= i_rx_level_code;
      level_sync <= level_meta;
      fault_meta <= {i_tx_current_limit, i_tx_open_circuit};
      fault_sync <= fault_meta;
      fault_prev <= fault_sync;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      irq_mask <= MASK_RESET;
      loop_ctrl <= LOOP_RESET;
      o_rdata <= 8'h00;
    end
    else
    begin
      if (mask_wr)
        irq_mask <= i_wdata & STATUS_FIELDS;
      if (loop_wr)
        loop_ctrl <= i_wdata & LOOP_FIELDS;
      o_rdata <= i_rd ? read_word : 8'h00;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      pend_open <= 1'b0;
      pend_limit <= 1'b0;
      ja_limit_flag <= 1'b0;
      ja_near_prev <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      pend_open <= next_pend_open;
      pend_limit <= next_pend_limit;
      ja_limit_flag <= next_ja_limit;
      ja_near_prev <= ja_near;
      o_irq <= next_irq;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_tx_line <= '0;
      o_ja_in <= '0;
      o_rx_framer <= '0;
    end
    else
    begin
      o_tx_line <= next_tx_line;
      o_ja_in <= next_ja_in;
      o_rx_framer <= next_rx_framer;
    end
  end

  composite_clock_encoder cc_encoder (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_enable(i_composite_clock_mode),
    .i_with_400hz(i_cc_with_400hz),
    .o_line(cc_line),
    .o_frame_mark(o_cc_frame_mark)
  );

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  t1_hi_rates_a: assert property (
    !i_e1_mode && i_mclk_sel == 4'b1101 |-> o_mclk_freq == MCLK_16384)
    else $error("T1 low source select decode wrong");
  e1_cc_rate_a: assert property (
    i_e1_mode && i_mclk_sel == 4'b0010 |-> o_mclk_freq == MCLK_12800 && o_cdr_pll_enable)
    else $error("E1 12.8 MHz decode wrong");
  pll_follow_a: assert property (
    o_mclk_freq == MCLK_12800 |-> o_cdr_pll_enable)
    else $error("conversion PLL off at 12.8 MHz");
  level_read_a: assert property (
    i_rd && sel_level |=> o_rdata == {4'h0, $past(level_sync)})
    else $error("level read mismatch");
  fault_live_a: assert property (
    ##1 fault_meta[0] |-> ##1 status_word[BIT_OPEN_CIRCUIT])
    else $error("open circuit bit not following");
  limit_live_a: assert property (
    fault_meta[1] |=> status_word[BIT_CURRENT_LIMIT])
    else $error("current limit bit not following");
  ja_trip_a: assert property (
    ja_near && !ja_near_prev |=> ja_limit_flag)
    else $error("jitter limit trip lost");
  ja_clear_a: assert property (
    status_rd && !ja_trip |=> !ja_limit_flag)
    else $error("jitter limit not cleared by read");
  edge_irq_a: assert property (
    open_edge && irq_mask[BIT_OPEN_CIRCUIT] |=> o_irq [*1] ##1 (o_irq || $past(status_rd)))
    else $error("open circuit edge did not interrupt");
  masked_quiet_a: assert property (
    irq_mask == 8'h00 && $past(irq_mask) == 8'h00 |-> !o_irq)
    else $error("interrupt with all masked");
  remote_path_a: assert property (
    remote_loop && !local_loop |=> o_tx_line == $past(i_rx_line) && o_ja_in == $past(i_rx_line))
    else $error("remote loop path wrong");
  local_path_a: assert property (
    local_loop && !i_ja_enable |=> o_rx_framer == $past(tx_source))
    else $error("local loop path wrong");
  loop_reset_a: assert property (
    $past(i_reset) |-> loop_ctrl == LOOP_RESET)
    else $error("loopback not cleared by reset");
  t1_cc_rate_a: assert property (
    !i_e1_mode && i_mclk_sel == 4'b0011 |-> o_mclk_freq == MCLK_12800)
    else $error("T1 12.8 MHz decode wrong");
  e1_top_rate_a: assert property (
    i_e1_mode && i_mclk_sel == 4'b1100 |-> o_mclk_freq == MCLK_16384)
    else $error("E1 16.384 MHz decode wrong");
  e1_bad_combo_a: assert property (
    i_e1_mode && i_mclk_sel.jitter_src == 2'b01 |-> o_mclk_freq == MCLK_INVALID)
    else $error("E1 illegal select not flagged");
  pll_off_a: assert property (
    i_mclk_sel.jitter_src == 2'b00 |-> !o_cdr_pll_enable)
    else $error("conversion PLL on without source select");
  ja_empty_trip_a: assert property (
    i_ja_fill <= JA_LIMIT_MARGIN && !ja_near_prev |=> ja_limit_flag)
    else $error("near empty trip lost");
  ja_irq_a: assert property (
    ja_trip && irq_mask[BIT_JITTER_LIMIT] |=> o_irq)
    else $error("jitter trip did not interrupt");
  irq_hold_a: assert property (
    o_irq && !status_rd && !$past(mask_wr) |=> o_irq)
    else $error("interrupt dropped while pending");
  irq_clear_a: assert property (
    status_rd && !open_edge && !limit_edge && !ja_trip |=> !o_irq)
    else $error("interrupt stayed after status read");
  status_read_a: assert property (
    status_rd |=> o_rdata[BIT_OPEN_CIRCUIT] == $past(open_now) && o_rdata[BIT_CURRENT_LIMIT] == $past(limit_now))
    else $error("status read lost fault bits");
  limit_rise_a: assert property (
    fault_meta[1] && !fault_sync[1] |=> limit_edge)
    else $error("current limit rise not seen");
  loop_write_a: assert property (
    loop_wr |=> remote_loop == $past(i_wdata[BIT_REMOTE_LOOP]) && local_loop == $past(i_wdata[BIT_LOCAL_LOOP]))
    else $error("loopback write lost");
  local_ja_a: assert property (
    local_loop && i_ja_enable |=> o_rx_framer == $past(i_ja_out) && o_ja_in == $past(tx_source))
    else $error("local loop bypassed attenuator");

  remote_cov: cover property (remote_loop ##1 !remote_loop);
  trip_cov: cover property (ja_trip ##[1:20] status_rd);
  irq_cov: cover property (!o_irq ##1 o_irq);
  bad_sel_cov: cover property (o_mclk_freq == MCLK_INVALID);

endmodule : line_interface_status_loopback

// File: src/line_interface_pkg.sv
package line_interface_pkg;

  // Register addresses on the control port
  localparam logic [7:0] ADDR_RX_LEVEL = 8'h11;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h15;
  localparam logic [7:0] ADDR_LOOPBACK = 8'h20;

  // Field positions
  localparam int BIT_OPEN_CIRCUIT = 1;
  localparam int BIT_CURRENT_LIMIT = 2;
  localparam int BIT_JITTER_LIMIT = 4;
  localparam int BIT_REMOTE_LOOP = 2;
  localparam int BIT_LOCAL_LOOP = 3;

  // Implemented bits and reset values
  localparam logic [7:0] STATUS_FIELDS = 8'h16;
  localparam logic [7:0] LOOP_FIELDS = 8'h0C;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] LOOP_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Jitter attenuator FIFO limits, in bits
  localparam logic [7:0] JA_FIFO_DEPTH = 8'h80;
  localparam logic [7:0] JA_LIMIT_MARGIN = 8'h04;

  // Composite clock timing
  localparam int CLK_HZ = 20000000;
  localparam int CC_BIT_HZ = 64000;
  localparam int CC_FRAME_HZ = 8000;
  localparam int CC_SUPER_HZ = 400;
  localparam int CC_TICK_HZ = 2 * CC_BIT_HZ;
  localparam int CC_BITS_PER_FRAME = CC_BIT_HZ / CC_FRAME_HZ;
  localparam int CC_FRAMES_PER_SUPER = CC_FRAME_HZ / CC_SUPER_HZ;
  localparam logic [24:0] CC_ACC_STEP = 25'(CC_TICK_HZ);
  localparam logic [24:0] CC_ACC_WRAP = 25'(CLK_HZ);
  localparam logic [2:0] CC_LAST_BIT = 3'(CC_BITS_PER_FRAME - 1);
  localparam logic [4:0] CC_LAST_FRAME = 5'(CC_FRAMES_PER_SUPER - 1);

  typedef struct packed {
    logic pos;
    logic neg;
  } line_pair_t;

  typedef struct packed {
    logic [1:0] prescale;    // {mclk_prescale_sel_hi, mclk_prescale_sel_lo}
    logic [1:0] jitter_src;  // {jitter_clock_src_sel_hi, jitter_clock_src_sel_lo}
  } mclk_sel_t;

  typedef enum logic [3:0] {
    MCLK_1544 = 4'h0,
    MCLK_3088 = 4'h1,
    MCLK_6176 = 4'h2,
    MCLK_12352 = 4'h3,
    MCLK_12800 = 4'h4,
    MCLK_2048 = 4'h5,
    MCLK_4096 = 4'h6,
    MCLK_8192 = 4'h7,
    MCLK_16384 = 4'h8,
    MCLK_INVALID = 4'hF
  } mclk_freq_t;

endpackage : line_interface_pkg

// File: src/composite_clock_encoder.sv
`timescale 1ns/1ns
module composite_clock_encoder
  import line_interface_pkg::*;
(
  input wire logic i_mclk,          // Master clock
  input wire logic i_reset,         // Sync reset, high
  input wire logic i_enable,        // Composite clock mode
  input wire logic i_with_400hz,    // Embed 400 Hz too
  output line_pair_t o_line,        // AMI pulse pair
  output logic o_frame_mark         // Pulse at 8 kHz violation
);

  logic [24:0] acc;
  logic half;
  logic [2:0] bit_idx;
  logic [4:0] frame_idx;
  logic last_pol;

  wire [25:0] acc_sum = {1'b0, acc} + {1'b0, CC_ACC_STEP};
  wire tick = i_enable && (acc_sum >= {1'b0, CC_ACC_WRAP});
  wire [24:0] next_acc = tick ? 25'(acc_sum - {1'b0, CC_ACC_WRAP}) : acc_sum[24:0];
  wire emit = tick && !half;
  // Dropping the violation once per 20 frames carries the 400 Hz
  wire skip_bpv = i_with_400hz && (frame_idx == CC_LAST_FRAME);
  wire violation = (bit_idx == CC_LAST_BIT) && !skip_bpv;
  wire next_pol = violation ? last_pol : !last_pol;
  wire bit_end = tick && half;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || !i_enable)
    begin
      acc <= 25'h0000000;
      half <= 1'b0;
      bit_idx <= 3'h0;
      frame_idx <= 5'h00;
      last_pol <= 1'b0;
      o_line <= '0;
      o_frame_mark <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      if (tick)
        half <= !half;
      if (emit)
        last_pol <= next_pol;
      if (emit)
        o_line <= next_pol ? 2'b10 : 2'b01;
      else if (bit_end)
        o_line <= '0;
      o_frame_mark <= emit && violation;
      if (bit_end)
        bit_idx <= (bit_idx == CC_LAST_BIT) ? 3'h0 : 3'(bit_idx + 3'h1);
      if (bit_end && bit_idx == CC_LAST_BIT)
        frame_idx <= (frame_idx == CC_LAST_FRAME) ? 5'h00 : 5'(frame_idx + 5'h01);
    end
  end

  bpv_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    emit && violation |=> last_pol == $past(last_pol))
    else $error("violation pulse did not repeat polarity");
  alt_mark_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    emit && (bit_idx != CC_LAST_BIT || skip_bpv) |=> last_pol != $past(last_pol))
    else $error("ordinary mark did not alternate");
  super_cov: cover property (@(posedge i_mclk) disable iff (i_reset)
    emit && skip_bpv && bit_idx == CC_LAST_BIT);

endmodule : composite_clock_encoder

// File: verif/line_side_model.sv
`timescale 1ns/1ns
module line_side_model
  import line_interface_pkg::*;
(
  input wire logic i_mclk,          // Master clock
  input wire logic i_open,          // Open circuit request
  input wire logic i_limit,         // Overload request
  input wire logic [3:0] i_level,   // Level to present
  output logic o_open_circuit,      // Open circuit detect
  output logic o_current_limit,     // Limiter active
  output logic [3:0] o_level_code,  // Analog level code
  output line_pair_t o_rx_line      // Received symbols
);
  logic [1:0] phase;
  initial
  begin
    phase = 2'h0;
    o_open_circuit = 1'b0;
    o_current_limit = 1'b0;
    o_level_code = 4'h0;
    o_rx_line = 2'h0;
  end
  // AMI mark, space, opposite mark, space: never two marks alike in a row
  always @(negedge i_mclk)
  begin
    phase <= phase + 2'h1;
    o_rx_line <= (phase == 2'h0) ? 2'h2 : (phase == 2'h2) ? 2'h1 : 2'h0;
    o_open_circuit <= i_open;
    o_current_limit <= i_limit;
    o_level_code <= i_level;
  end
endmodule : line_side_model

// File: verif/line_interface_status_loopback_tb.sv
`timescale 1ns/1ns
module line_interface_status_loopback_tb;
  import line_interface_pkg::*;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_e1_mode = 1'b0, i_ja_enable = 1'b0;
  logic i_composite_clock_mode = 1'b0, cc_400 = 1'b0, open_cmd = 1'b0, limit_cmd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_ja_fill = 8'h40, o_rdata, rd_val;
  logic [3:0] level_cmd = 4'h0, level_code;
  logic o_cdr_pll_enable, o_cc_frame_mark, o_irq, open_circuit, current_limit;
  mclk_sel_t i_mclk_sel = 4'h0;
  mclk_freq_t o_mclk_freq;
  line_pair_t i_tx_fmt = 2'h0, i_ja_out = 2'h0, rx_line, o_ja_in, o_rx_framer, o_tx_line, exp_pair;
  int err_total = 0, num_checks = 0, cycles = 0, marks;
  `define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end
  always #25 i_mclk = ~i_mclk;
  line_side_model far_side (.i_mclk(i_mclk), .i_open(open_cmd), .i_limit(limit_cmd), .i_level(level_cmd),
    .o_open_circuit(open_circuit), .o_current_limit(current_limit), .o_level_code(level_code),
    .o_rx_line(rx_line));
  line_interface_status_loopback DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_e1_mode(i_e1_mode),
    .i_mclk_sel(i_mclk_sel), .o_mclk_freq(o_mclk_freq), .o_cdr_pll_enable(o_cdr_pll_enable),
    .i_rx_level_code(level_code), .i_tx_open_circuit(open_circuit), .i_tx_current_limit(current_limit),
    .i_ja_fill(i_ja_fill), .i_ja_enable(i_ja_enable), .i_rx_line(rx_line), .i_tx_fmt(i_tx_fmt),
    .i_ja_out(i_ja_out), .o_ja_in(o_ja_in), .o_rx_framer(o_rx_framer), .o_tx_line(o_tx_line),
    .i_composite_clock_mode(i_composite_clock_mode), .i_cc_with_400hz(cc_400),
    .o_cc_frame_mark(o_cc_frame_mark), .o_irq(o_irq));
  task automatic close_out();
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk) {i_wr, i_addr, i_wdata} = {1'b1, a, d};
    @(negedge i_mclk) i_wr = 1'b0;
  endtask : wr
  // Data lands in the cycle after the strobe edge, which this negedge falls in
  task automatic rd(input logic [7:0] a);
    @(negedge i_mclk) {i_rd, i_addr} = {1'b1, a};
    @(negedge i_mclk) i_rd = 1'b0;
    rd_val = o_rdata;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : idle
  task automatic reset_values();
    logic [7:0] addrs [5] = '{ADDR_RX_LEVEL, ADDR_FAULT_STATUS, ADDR_IRQ_MASK, ADDR_LOOPBACK, 8'h33};
    foreach (addrs[k])
    begin
      rd(addrs[k]);
      `CHK("reset read", 8'h00, rd_val)
    end
    `CHK("irq idle", 1'b0, o_irq)
  endtask : reset_values
  task automatic clock_decode();
    logic [4:0] sel [8] = '{5'h00, 5'h0C, 5'h03, 5'h0D, 5'h14, 5'h12, 5'h1C, 5'h11};
    mclk_freq_t fr [8] = '{MCLK_1544, MCLK_12352, MCLK_12800, MCLK_16384, MCLK_4096, MCLK_12800, MCLK_16384,
      MCLK_INVALID};
    foreach (sel[k])
    begin
      @(negedge i_mclk) {i_e1_mode, i_mclk_sel} = sel[k];
      #1 `CHK("clock rate", fr[k], o_mclk_freq)
      `CHK("pll enable", |sel[k][1:0], o_cdr_pll_enable)
    end
  endtask : clock_decode
  task automatic level_and_faults();
    level_cmd = 4'hF;
    idle(5);
    rd(ADDR_RX_LEVEL);
    `CHK("level code", 8'h0F, rd_val)
    wr(ADDR_IRQ_MASK, 8'h02);
    open_cmd = 1'b1;
    limit_cmd = 1'b1;
    idle(6);
    `CHK("irq open rise", 1'b1, o_irq)
    rd(ADDR_FAULT_STATUS);
    `CHK("status faults", 8'h06, rd_val)
    idle(1);
    `CHK("irq after read", 1'b0, o_irq)
    limit_cmd = 1'b0;
    idle(6);
    `CHK("irq masked limit", 1'b0, o_irq)
    open_cmd = 1'b0;
    idle(6);
    `CHK("irq open fall", 1'b1, o_irq)
    rd(ADDR_FAULT_STATUS);
    `CHK("status clear", 8'h00, rd_val)
  endtask : level_and_faults
  task automatic jitter_trip();
    wr(ADDR_IRQ_MASK, 8'h10);
    i_ja_fill = 8'd123;
    idle(4);
    rd(ADDR_FAULT_STATUS);
    `CHK("fill below trip", 8'h00, rd_val)
    i_ja_fill = 8'd124;
    idle(3);
    `CHK("irq jitter", 1'b1, o_irq)
    rd(ADDR_FAULT_STATUS);
    `CHK("jitter set", 8'h10, rd_val)
    rd(ADDR_FAULT_STATUS);
    `CHK("jitter cleared", 8'h00, rd_val)
    `CHK("irq jitter clear", 1'b0, o_irq)
    i_ja_fill = 8'h40;
    rd(ADDR_IRQ_MASK);
    `CHK("mask readback", 8'h10, rd_val)
    i_ja_fill = 8'h04;
    idle(2);
    rd(ADDR_FAULT_STATUS);
    `CHK("jitter empty trip", 8'h10, rd_val)
    i_ja_fill = 8'h40;
  endtask : jitter_trip
  task automatic loopbacks();
    wr(ADDR_FAULT_STATUS, 8'h16);
    wr(ADDR_LOOPBACK, 8'h0C);
    rd(ADDR_LOOPBACK);
    `CHK("loop readback", 8'h0C, rd_val)
    rd(ADDR_FAULT_STATUS);
    `CHK("status read only", 8'h00, rd_val)
    wr(ADDR_LOOPBACK, 8'h04);
    repeat (4)
    begin
      @(negedge i_mclk) i_tx_fmt = ~i_tx_fmt;
      @(posedge i_mclk) exp_pair = rx_line;
      #1 `CHK("remote tx", exp_pair, o_tx_line)
      `CHK("remote framer", exp_pair, o_rx_framer)
    end
    wr(ADDR_LOOPBACK, 8'h08);
    repeat (4)
    begin
      @(negedge i_mclk) i_tx_fmt = (i_tx_fmt == 2'h2) ? 2'h1 : 2'h2;
      @(posedge i_mclk) exp_pair = i_tx_fmt;
      #1 `CHK("local tx", exp_pair, o_tx_line)
      `CHK("local ja in", exp_pair, o_ja_in)
      `CHK("local framer", exp_pair, o_rx_framer)
    end
    @(negedge i_mclk) {i_ja_enable, i_ja_out} = 3'h6;
    @(posedge i_mclk) #1 `CHK("framer via ja", 2'h2, o_rx_framer)
    @(negedge i_mclk) i_reset = 1'b1;
    idle(2);
    i_reset = 1'b0;
    rd(ADDR_LOOPBACK);
    `CHK("loop after reset", 8'h00, rd_val)
  endtask : loopbacks
  // Marks every 2500 cycles; the 400 Hz variant drops the one of frame 19
  task automatic composite_marks(input logic with_400, input int n, input int exp_marks);
    marks = 0;
    @(negedge i_mclk) {i_composite_clock_mode, cc_400} = {1'b1, with_400};
    repeat (n)
    begin
      @(posedge i_mclk) #1 marks += o_cc_frame_mark;
      if (o_tx_line == 2'h3)
        `CHK("ami pair", 2'h0, o_tx_line)
    end
    `CHK("violation marks", exp_marks, marks)
    @(negedge i_mclk) i_composite_clock_mode = 1'b0;
  endtask : composite_marks
  initial
  begin
    idle(5);
    i_reset = 1'b0;
    reset_values();
    clock_decode();
    level_and_faults();
    jitter_trip();
    loopbacks();
    composite_marks(1'b0, 7600, 3);
    composite_marks(1'b1, 51000, 19);
    close_out();
  end
endmodule : line_interface_status_loopback_tb
